//--- ebmc_pkg.sv
// constants, register map and state encoding of the energy buffer mode control
// assumes a 32-bit Avalon-MM register bus; byte address is four times the index
//
// Overview of operation
// RULE1: three modes: continuous, on-demand, start-pin auto mode on two-wire variant only.
// RULE2: states standby, charge, active; standby rests whenever no mode is enabled.
// RULE3: write-only command holds on-demand, continuous, force-active, optimizer-clear bits.
// RULE4: writing one to optimizer clear erases result of selected learning set.
// RULE5: config bit 7 enables auto mode; default one two-wire, zero four-wire.
// RULE6: four-wire variant ignores writing one to auto enable; it stays zero.
// RULE7: setting continuous bit charges the capacitor, then idles the converter.
// RULE8: continuous mode re-enables converter whenever capacitor reading drops below target.
// RULE9: continuous mode force-active makes stored energy available at once.
// RULE10: after an energy pulse in continuous mode, recharge happens automatically.
// RULE11: ready output rises when capacitor is charged or recharged to target.
// RULE12: host may alternate active and recharge in continuous mode freely.
// RULE13: continuous mode ends only when continuous and force-active bits are clear.
// RULE14: on-demand set by bit 0, ended when it and force-active clear.
// RULE15: with auto enabled, start rising edge starts one charge then active.
// RULE16: a new command value is evaluated on the next clock cycle.
package ebmc_pkg;
  localparam logic [7:0] EBMC_IDX_STATUS = 8'h01;
  localparam logic [7:0] EBMC_IDX_IRQ_STATUS = 8'h02;
  localparam logic [7:0] EBMC_IDX_IRQ_MASK = 8'h03;
  localparam logic [7:0] EBMC_IDX_COMMAND = 8'h08;
  localparam logic [7:0] EBMC_IDX_AUTO_CFG = 8'h11;
  localparam logic [7:0] EBMC_IDX_TARGET = 8'h20;
  localparam logic [7:0] EBMC_IDX_PROFILE = 8'h21;
  localparam logic [7:0] EBMC_IDX_OPT_RESULT = 8'h22;
  localparam int EBMC_CMD_EOD = 0;
  localparam int EBMC_CMD_ECM = 1;
  localparam int EBMC_CMD_ACT = 2;
  localparam int EBMC_CMD_OPT_CLR = 3;
  localparam int EBMC_CFG_AUTO = 7;
  localparam int EBMC_IRQ_CHARGED = 0;
  localparam int EBMC_IRQ_ACTIVE = 1;
  localparam int EBMC_IRQ_STANDBY = 2;
  localparam int EBMC_IRQ_BITS = 3;
  localparam logic [7:0] EBMC_TARGET_RESET = 8'h80;
  localparam logic [5:0] EBMC_PROFILE_RESET = 6'h01;
  localparam logic [31:0] EBMC_UNMAPPED_DATA = 32'h00000000;
  typedef enum logic [1:0] {
    EBMC_STANDBY = 2'b00,
    EBMC_CHARGE = 2'b01,
    EBMC_IDLE = 2'b10,
    EBMC_ACTIVE = 2'b11
  } ebmc_state_type;
endpackage

//--- ebmc_opt_mem.sv
// learned optimizer results, one word per learning set
// assumes one write port; clear has priority over a learned update
`timescale 1ns/10ps
`default_nettype none
module ebmc_opt_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic core_clk,
  input wire logic [AW-1:0] addr,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] store_reg [DEPTH];
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      store_reg[addr] <= wr_data;
    end
    rd_data <= store_reg[addr];
  end
endmodule
`default_nettype wire

//--- ebmc_mode_ctrl.sv
// mode and state control of the energy buffer, with its register slave
// assumes an Avalon-MM master, a capacitor level reading and a synchronous start pin
`timescale 1ns/10ps
`default_nettype none
module ebmc_mode_ctrl
  import ebmc_pkg::*;
#(
  parameter bit TWO_WIRE_VARIANT = 1'b1,
  parameter int LEVEL_W = 8,
  parameter int OPT_W = 16,
  parameter int PROFILES = 64
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [LEVEL_W-1:0] cap_level,
  input wire logic start_pin,
  input wire logic load_idle,
  input wire logic opt_update,
  input wire logic [OPT_W-1:0] opt_update_value,
  output logic converter_en,
  output logic regulated_output_en,
  output logic output_ready,
  output logic irq
);
  ebmc_state_type state_reg, state_next;
  logic [3:0] command_reg;
  logic auto_en_reg;
  logic [LEVEL_W-1:0] target_reg;
  logic [5:0] profile_reg;
  logic [EBMC_IRQ_BITS-1:0] irq_status_reg, irq_mask_reg, irq_event;
  logic auto_run_reg, start_prev_reg, auto_long_reg;
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic conv_reg, reg_out_reg, ready_reg, irq_reg;
  logic [OPT_W-1:0] opt_rdata;

  // bus decode; one wait cycle lets read data settle in a register
  wire [7:0] word_idx = avs_address[9:2];
  wire bus_req = avs_read | avs_write;
  wire bus_take = bus_req & ~wait_reg;
  wire wr_take = avs_write & ~wait_reg & avs_byteenable[0];
  wire wr_command = wr_take & (word_idx == EBMC_IDX_COMMAND);
  wire wr_auto = wr_take & (word_idx == EBMC_IDX_AUTO_CFG);
  wire wr_target = wr_take & (word_idx == EBMC_IDX_TARGET);
  wire wr_profile = wr_take & (word_idx == EBMC_IDX_PROFILE);
  wire wr_irq_status = wr_take & (word_idx == EBMC_IDX_IRQ_STATUS);
  wire wr_irq_mask = wr_take & (word_idx == EBMC_IDX_IRQ_MASK);

  wire eod = command_reg[EBMC_CMD_EOD];
  wire ecm = command_reg[EBMC_CMD_ECM];
  wire act = command_reg[EBMC_CMD_ACT];
  wire cap_full = cap_level >= target_reg;
  wire start_rise = start_pin & ~start_prev_reg;
  // RULE15 auto trigger
  wire auto_trigger = auto_en_reg & start_rise & (state_reg == EBMC_STANDBY);
  // short pulse ends on no-load, long pulse ends when start falls
  wire auto_done = auto_long_reg ? ~start_pin : load_idle;
  // RULE2 standby unless a mode
  wire any_mode = eod | ecm | act | auto_run_reg;

  // RULE3 command bit decode
  // RULE4 optimizer clear
  wire opt_clear = wr_command & avs_writedata[EBMC_CMD_OPT_CLR];
  wire opt_wr = opt_clear | opt_update;
  wire [OPT_W-1:0] opt_wdata = opt_clear ? '0 : opt_update_value;

  ebmc_opt_mem #(
    .WIDTH(OPT_W),
    .DEPTH(PROFILES),
    .AW(6)
  ) u_opt_mem (
    .core_clk(core_clk),
    .addr(profile_reg),
    .wr_en(opt_wr),
    .wr_data(opt_wdata),
    .rd_data(opt_rdata)
  );

  // RULE1 mode selection
  // RULE16 next-cycle evaluation
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      EBMC_STANDBY: begin
        if (act) begin
          state_next = EBMC_ACTIVE;
        end else if (ecm | eod | auto_run_reg) begin
          state_next = EBMC_CHARGE;
        end
      end
      EBMC_CHARGE: begin
        if (act) begin
          state_next = EBMC_ACTIVE;
        end else if (!any_mode) begin
          state_next = EBMC_STANDBY;
        end else if (cap_full) begin
          // RULE7 idle converter
          state_next = (eod | auto_run_reg) ? EBMC_ACTIVE : EBMC_IDLE;
        end
      end
      EBMC_IDLE: begin
        // RULE9 immediate active
        if (act) begin
          state_next = EBMC_ACTIVE;
        end else if (!any_mode) begin
          state_next = EBMC_STANDBY;
        // RULE8 refresh below target
        end else if (!cap_full) begin
          state_next = EBMC_CHARGE;
        end
      end
      EBMC_ACTIVE: begin
        // RULE13 leave only when cleared
        // RULE14 on-demand end
        if (act | eod) begin
          state_next = EBMC_ACTIVE;
        // RULE10 automatic recharge
        // RULE12 toggle active
        end else if (ecm) begin
          state_next = EBMC_CHARGE;
        end else if (auto_run_reg & ~auto_done) begin
          state_next = EBMC_ACTIVE;
        end else begin
          state_next = EBMC_STANDBY;
        end
      end
      default: state_next = EBMC_STANDBY;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= EBMC_STANDBY;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      command_reg <= 4'h0;
    end else if (wr_command) begin
      command_reg <= {1'b0, avs_writedata[2:0]};
    end
  end

  // RULE5 auto enable default
  // RULE6 four-wire stays zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      auto_en_reg <= TWO_WIRE_VARIANT;
    end else if (wr_auto) begin
      auto_en_reg <= avs_writedata[EBMC_CFG_AUTO] & TWO_WIRE_VARIANT;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      target_reg <= EBMC_TARGET_RESET[LEVEL_W-1:0];
      profile_reg <= EBMC_PROFILE_RESET;
    end else begin
      if (wr_target) begin
        target_reg <= avs_writedata[LEVEL_W-1:0];
      end
      if (wr_profile) begin
        profile_reg <= avs_writedata[5:0];
      end
    end
  end

  // auto cycle: long pulse if start still high when active begins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      start_prev_reg <= 1'b0;
      auto_run_reg <= 1'b0;
      auto_long_reg <= 1'b0;
    end else begin
      start_prev_reg <= start_pin;
      if (auto_trigger) begin
        auto_run_reg <= 1'b1;
      end else if (state_reg == EBMC_ACTIVE && state_next == EBMC_STANDBY) begin
        auto_run_reg <= 1'b0;
      end else if (!auto_en_reg && state_reg == EBMC_STANDBY) begin
        auto_run_reg <= 1'b0;
      end
      if (state_reg == EBMC_CHARGE && state_next == EBMC_ACTIVE) begin
        auto_long_reg <= start_pin;
      end
    end
  end

  // events; set wins over a write-one clear in the same cycle
  assign irq_event[EBMC_IRQ_CHARGED] = state_reg == EBMC_CHARGE && state_next != EBMC_CHARGE
    && cap_full;
  assign irq_event[EBMC_IRQ_ACTIVE] = state_reg != EBMC_ACTIVE && state_next == EBMC_ACTIVE;
  assign irq_event[EBMC_IRQ_STANDBY] = state_reg != EBMC_STANDBY && state_next == EBMC_STANDBY;
  wire [EBMC_IRQ_BITS-1:0] irq_clear = wr_irq_status ? avs_writedata[EBMC_IRQ_BITS-1:0] : '0;
  wire [EBMC_IRQ_BITS-1:0] irq_status_next = (irq_status_reg & ~irq_clear) | irq_event;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_status_reg <= '0;
      irq_mask_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      if (wr_irq_mask) begin
        irq_mask_reg <= avs_writedata[EBMC_IRQ_BITS-1:0];
      end
      irq_reg <= |(irq_status_next & (wr_irq_mask ? avs_writedata[EBMC_IRQ_BITS-1:0]
        : irq_mask_reg));
    end
  end

  // RULE11 ready once charged
  wire ready_next = (state_next == EBMC_IDLE) || (state_next == EBMC_ACTIVE);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      conv_reg <= 1'b0;
      reg_out_reg <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      conv_reg <= state_next == EBMC_CHARGE;
      reg_out_reg <= state_next == EBMC_ACTIVE;
      ready_reg <= ready_next;
    end
  end

  // read mux; command and auto config are write-only and read zero
  wire [31:0] status_word = {28'h0000000, ready_reg, auto_en_reg, state_reg};
  wire [31:0] read_mux =
    (word_idx == EBMC_IDX_STATUS) ? status_word :
    (word_idx == EBMC_IDX_IRQ_STATUS) ? {29'h0, irq_status_reg} :
    (word_idx == EBMC_IDX_IRQ_MASK) ? {29'h0, irq_mask_reg} :
    (word_idx == EBMC_IDX_TARGET) ? {{(32-LEVEL_W){1'b0}}, target_reg} :
    (word_idx == EBMC_IDX_PROFILE) ? {26'h0, profile_reg} :
    (word_idx == EBMC_IDX_OPT_RESULT) ? {{(32-OPT_W){1'b0}}, opt_rdata} :
    EBMC_UNMAPPED_DATA;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
    end else begin
      wait_reg <= ~(bus_req & wait_reg);
      if (avs_read & wait_reg) begin
        rdata_reg <= read_mux;
      end
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;
  assign converter_en = conv_reg;
  assign regulated_output_en = reg_out_reg;
  assign output_ready = ready_reg;
  assign irq = irq_reg;

  sequence s_cmd_ecm_write;
    wr_command && avs_writedata[EBMC_CMD_ECM] && !avs_writedata[EBMC_CMD_ACT];
  endsequence
  sequence s_charge_begins;
    ##1 (state_reg == EBMC_STANDBY) ##1 (state_reg == EBMC_CHARGE);
  endsequence

  a_cont_start_charge: assert property (@(posedge core_clk) disable iff (rst) // RULE7
    (s_cmd_ecm_write and state_reg == EBMC_STANDBY && !auto_run_reg) |-> s_charge_begins)
    else $error("continuous command did not start a charge");
  a_refresh_low_cap: assert property (@(posedge core_clk) disable iff (rst) // RULE8
    (state_reg == EBMC_IDLE && !cap_full && !act && any_mode)
    |=> converter_en)
    else $error("low capacitor did not restart the converter");
  a_force_active: assert property (@(posedge core_clk) disable iff (rst) // RULE9
    (wr_command && avs_writedata[EBMC_CMD_ACT]) |=> ##1 regulated_output_en)
    else $error("force active not honoured within two cycles");
  a_recharge_after: assert property (@(posedge core_clk) disable iff (rst) // RULE10
    (state_reg == EBMC_ACTIVE && ecm && !act && !eod) |=> state_reg == EBMC_CHARGE)
    else $error("no recharge after active in continuous mode");
  a_ready_level: assert property (@(posedge core_clk) disable iff (rst) // RULE11
    $rose(output_ready) |-> $past(state_reg) != EBMC_STANDBY || act)
    else $error("ready rose without a charge");
  a_standby_hold: assert property (@(posedge core_clk) disable iff (rst) // RULE13
    (state_reg == EBMC_ACTIVE && (ecm || act)) |=> state_reg != EBMC_STANDBY)
    else $error("left continuous mode with bits still set");
  a_auto_locked: assert property (@(posedge core_clk) disable iff (rst) // RULE6
    !TWO_WIRE_VARIANT |-> !auto_en_reg)
    else $error("auto mode enabled on four-wire variant");
  a_auto_charge: assert property (@(posedge core_clk) disable iff (rst) // RULE15
    auto_trigger && !act |=> state_reg == EBMC_STANDBY ##1 state_reg == EBMC_CHARGE)
    else $error("start edge did not begin a charge");
  a_idle_standby: assert property (@(posedge core_clk) disable iff (rst) // RULE2
    (!any_mode && state_reg != EBMC_ACTIVE) |=> state_reg == EBMC_STANDBY)
    else $error("not in standby with no mode");
  a_irq_level: assert property (@(posedge core_clk) disable iff (rst) // interrupt level follows status and mask
    irq == |(irq_status_reg & irq_mask_reg))
    else $error("interrupt does not follow status and mask");
endmodule
`default_nettype wire

//--- ebmc_cap_model.sv
// storage capacitor level model seen by the mode control
// assumes converter_en charges it and the bench's drain input discharges it
`timescale 1ns/10ps
`default_nettype none
module ebmc_cap_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic converter_en,
  input wire logic drain,
  output logic [7:0] cap_level
);
  // coarse steps keep each charge cycle short
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cap_level <= 8'h00;
    end else if (converter_en) begin
      cap_level <= (cap_level > 8'hEF) ? 8'hFF : cap_level + 8'h10;
    end else if (drain) begin
      cap_level <= (cap_level < 8'h20) ? 8'h00 : cap_level - 8'h20;
    end
  end
endmodule
`default_nettype wire

//--- energy_buffer_mode_control_bench.sv
// self-checking bench of the energy buffer mode control
// assumes ebmc_pkg, ebmc_mode_ctrl and ebmc_cap_model are compiled first
`timescale 1ns/10ps
`default_nettype none
module energy_buffer_mode_control_bench;
  logic core_clk, rst, avs_read, avs_write, avs_waitrequest, sel4, drain;
  logic start_pin, load_idle, opt_update, irq, converter_en;
  logic regulated_output_en, output_ready;
  logic [9:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd4;
  logic [7:0] cap_level;
  logic [15:0] opt_update_value;
  logic [3:0] obs;
  int fails, check_count;
  assign obs = {irq, output_ready, regulated_output_en, converter_en};
  always #12.5 core_clk = ~core_clk;
  ebmc_mode_ctrl u_dut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cap_level(cap_level), .start_pin(start_pin), .load_idle(load_idle),
    .opt_update(opt_update), .opt_update_value(opt_update_value),
    .converter_en(converter_en), .regulated_output_en(regulated_output_en),
    .output_ready(output_ready), .irq(irq));
  // four-wire variant shares the bus; only its read data is used
  ebmc_mode_ctrl #(.TWO_WIRE_VARIANT(1'b0)) u_dut_four (.core_clk(core_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(rd4),
    .avs_waitrequest(), .cap_level(cap_level), .start_pin(start_pin),
    .load_idle(load_idle), .opt_update(opt_update), .opt_update_value(opt_update_value),
    .converter_en(), .regulated_output_en(), .output_ready(), .irq());
  ebmc_cap_model u_cap (.core_clk(core_clk), .rst(rst), .converter_en(converter_en),
    .drain(drain), .cap_level(cap_level));
  task automatic results;
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one access; the extra edge keeps back-to-back requests apart
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    q = sel4 ? rd4 : avs_readdata;
    // one wait state: the answer stands at the second edge
    chk("bus latency", n, 32'h2);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input string nm, input logic [9:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask
  task automatic await(input logic [3:0] m, input logic [3:0] v);
    int n;
    n = 0;
    while ((obs & m) !== v && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    chk("outputs", {28'h0, obs & m}, {28'h0, v});
  endtask
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    {avs_read, avs_write, sel4, drain, start_pin, load_idle, opt_update} = 7'h00;
    avs_address = 10'h000;
    avs_writedata = 32'h00000000;
    opt_update_value = 16'h0000;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk("reset outputs", {28'h0, obs}, 32'h0);
    rdc("status", 10'h004, 32'h4);
    rdc("target", 10'h080, 32'h80);
    rdc("unmapped", 10'h3FC, 32'h0);
    sel4 <= 1'b1;
    rdc("status four", 10'h004, 32'h0);
    wr(10'h044, 32'h80);
    rdc("status four", 10'h004, 32'h0);
    sel4 <= 1'b0;
    $display("test reset done");
    wr(10'h00C, 32'h1);
    wr(10'h020, 32'h2);
    await(4'h1, 4'h1);
    await(4'h5, 4'h4);
    await(4'h8, 4'h8);
    rdc("status", 10'h004, 32'hE);
    rdc("irq status", 10'h008, 32'h1);
    wr(10'h008, 32'h7);
    await(4'h8, 4'h0);
    drain <= 1'b1;
    await(4'h1, 4'h1);
    drain <= 1'b0;
    await(4'h5, 4'h4);
    $display("test continuous done");
    for (int i = 0; i < 2; i++) begin
      wr(10'h020, 32'h6);
      // force active lands one edge after the write edge
      repeat (2) @(posedge core_clk);
      chk("active", {28'h0, obs & 4'h3}, 32'h2);
      drain <= 1'b1;
      repeat (3) @(posedge core_clk);
      drain <= 1'b0;
      wr(10'h020, 32'h2);
      await(4'h1, 4'h1);
      await(4'h5, 4'h4);
    end
    wr(10'h020, 32'h4);
    await(4'h2, 4'h2);
    rdc("status", 10'h004, 32'hF);
    wr(10'h020, 32'h0);
    await(4'h7, 4'h0);
    rdc("irq status", 10'h008, 32'h7);
    await(4'h8, 4'h8);
    wr(10'h00C, 32'h0);
    await(4'h8, 4'h0);
    wr(10'h008, 32'h7);
    $display("test active toggling done");
    wr(10'h020, 32'h1);
    await(4'h1, 4'h1);
    await(4'h7, 4'h6);
    wr(10'h020, 32'h0);
    await(4'h2, 4'h0);
    start_pin <= 1'b1;
    await(4'h1, 4'h1);
    await(4'h6, 4'h6);
    start_pin <= 1'b0;
    await(4'h2, 4'h0);
    // short start pulse: active holds until the load goes idle
    start_pin <= 1'b1;
    @(posedge core_clk);
    start_pin <= 1'b0;
    await(4'h6, 4'h6);
    repeat (4) @(posedge core_clk);
    chk("short pulse", {28'h0, obs & 4'h2}, 32'h2);
    load_idle <= 1'b1;
    await(4'h2, 4'h0);
    load_idle <= 1'b0;
    wr(10'h044, 32'h0);
    rdc("status", 10'h004, 32'h0);
    start_pin <= 1'b1;
    // a disabled trigger must leave the block at rest
    repeat (20) @(posedge core_clk);
    chk("no trigger", {28'h0, obs}, 32'h0);
    start_pin <= 1'b0;
    $display("test modes done");
    opt_update_value <= 16'hA5C3;
    opt_update <= 1'b1;
    @(posedge core_clk);
    opt_update <= 1'b0;
    // memory output lags a learned update by one edge
    @(posedge core_clk);
    rdc("optimizer", 10'h088, 32'hA5C3);
    wr(10'h020, 32'h0);
    rdc("optimizer", 10'h088, 32'hA5C3);
    wr(10'h020, 32'h8);
    rdc("optimizer", 10'h088, 32'h0);
    rdc("command", 10'h020, 32'h0);
    $display("test optimizer done");
    results();
  end
  // every test ends well inside this span
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    results();
  end
endmodule
`default_nettype wire
